// File: scmc_defs.svh
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH
// ****************************************
// Register offsets.
// ****************************************
`define SCMC_OFF_MODE 12'h000
`define SCMC_OFF_MISC 12'h004
`define SCMC_OFF_IRQ_STAT 12'h008
`define SCMC_OFF_IRQ_EN 12'h00c
`define SCMC_OFF_IRQ_CLR 12'h010
`define SCMC_OFF_CTL 12'h014
// ****************************************
// Field positions of the mode control and miscellaneous registers.
// ****************************************
`define SCMC_MODE_DIV_LSB 5
`define SCMC_MODE_FAST_BIT 4
`define SCMC_MODE_LRDY_BIT 3
`define SCMC_MODE_HRDY_BIT 2
`define SCMC_MODE_IDLE_BIT 1
`define SCMC_MODE_HL_BIT 0
`define SCMC_MISC_SYSON_BIT 7
// ****************************************
// Reset values.
// ****************************************
`define SCMC_MODE_RST 8'h03
`define SCMC_MISC_RST 8'h00
// ****************************************
// Ready counts, in oscillator cycles.
// ****************************************
`define SCMC_HI_XTAL_READY 512
`define SCMC_HI_RC_READY 16
`define SCMC_LO_XTAL_READY 128
`define SCMC_LO_RC_READY 2
`endif

// File: scmc_pkg.sv
package scmc_pkg;
  // Power modes of the device.
  typedef enum logic [2:0] {
    SCMC_NORMAL,
    SCMC_SLOW,
    SCMC_IDLE_NOCLK,
    SCMC_IDLE_CLK,
    SCMC_SLEEP_DEEP,
    SCMC_SLEEP_LIGHT
  } scmc_mode_t;
endpackage

// File: scmc_top.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "scmc_defs.svh"
// What this block does
// - High/low select at one routes the undivided high-speed clock to the system clock.
// - With select at zero, divider codes 000/001 pick substitute, 010..111 pick high/64..high/2.
// - Switching system clock from high-speed to substitute stops the high-speed oscillator.
// - High-speed source is crystal or RC, substitute is low crystal or RC, by option.
// - A time-base clock exists besides the substitute, from low crystal or RC by option.
// - Six modes gate CPU, system, substitute and time-base clocks as tabulated.
// - Halt with idle enable zero and watchdog off enters deep sleep, stopping all.
// - Deep sleep is refused while low-voltage detect enable is one.
// - Light sleep keeps the substitute clock running when the watchdog uses it.
// - Halt with idle enable one and idle sysclk zero enters unclocked idle.
// - Halt with idle enable one and idle sysclk one enters clocked idle.
// - Normal mode divides the high-speed clock by one to sixty-four.
// - Slow mode runs from the low-speed clock with high-speed clock off.
// - Fast wake-up runs on substitute clock after wake-up, only for the crystal source.
// - Low ready is zero in deep sleep, rises after 128 or 1~2 cycles.
// - High ready clears at power-on and sleep/unclocked idle, rises after 512 or 15~16.
// - Bits six to three of the miscellaneous register always read zero.
module scmc_top import scmc_pkg::*; #(
  parameter int HI_XTAL_READY = `SCMC_HI_XTAL_READY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hosc_clk_in,
  input wire logic losc_clk_in,
  input wire logic opt_hsrc_rc,
  input wire logic opt_lsrc_rc,
  input wire logic opt_tbc_rc,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_on,
  output logic sys_clk_en,
  output logic sub_clk_en,
  output logic tbc_clk_en,
  output logic cpu_run,
  output logic hosc_enable,
  output logic irq
);
  // ****************************************
  // Input synchronisers.
  // ****************************************
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] hist_ff;
  // The oscillator, halt and wake inputs pass two flip-flops before any logic looks at them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      hist_ff <= 4'h0;
    end else begin
      sync1_ff <= {wake_req, halt_req, losc_clk_in, hosc_clk_in};
      sync2_ff <= sync1_ff;
      hist_ff <= sync2_ff;
    end
  end
  wire h_tick = sync2_ff[0] & ~hist_ff[0];
  wire l_tick = sync2_ff[1] & ~hist_ff[1];
  wire halt_p = sync2_ff[2] & ~hist_ff[2];
  wire wake_p = sync2_ff[3] & ~hist_ff[3];

  // ****************************************
  // Registers.
  // ****************************************
  logic [2:0] div_sel_ff;
  logic fast_wake_ff;
  logic idle_en_ff;
  logic hl_sel_ff;
  logic idle_syson_ff;
  logic lvd_en_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_en_ff;
  logic hrdy_ff;
  logic lrdy_ff;
  scmc_mode_t mode_ff;
  wire wr = psel & penable & pwrite;
  wire rd_cyc = psel & ~penable;
  wire hit_mode = paddr == `SCMC_OFF_MODE;
  wire hit_misc = paddr == `SCMC_OFF_MISC;
  wire hit_stat = paddr == `SCMC_OFF_IRQ_STAT;
  wire hit_en = paddr == `SCMC_OFF_IRQ_EN;
  wire hit_clr = paddr == `SCMC_OFF_IRQ_CLR;
  wire hit_ctl = paddr == `SCMC_OFF_CTL;
  wire hit_any = hit_mode | hit_misc | hit_stat | hit_en | hit_clr | hit_ctl;
  wire [7:0] mode_rd = {div_sel_ff, fast_wake_ff, lrdy_ff, hrdy_ff, idle_en_ff, hl_sel_ff};
  // bits six to three read zero; low bits (reset flags) live elsewhere.
  wire [7:0] misc_rd = {idle_syson_ff, 7'h00};
  wire [31:0] rd_mux = hit_mode ? {24'h0, mode_rd} :
                       hit_misc ? {24'h0, misc_rd} :
                       hit_stat ? {29'h0, irq_stat_ff} :
                       hit_en ? {29'h0, irq_en_ff} :
                       hit_ctl ? {31'h0, lvd_en_ff} : 32'h0;

  // APB answers one cycle after setup, with an error for unmapped addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_cyc;
      pslverr <= rd_cyc & ~hit_any;
      if (rd_cyc && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Writable control fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {div_sel_ff, fast_wake_ff} <= 4'h0;
      idle_en_ff <= 1'(`SCMC_MODE_RST >> `SCMC_MODE_IDLE_BIT);
      hl_sel_ff <= 1'b1;
      idle_syson_ff <= 1'b0;
      lvd_en_ff <= 1'b0;
      irq_en_ff <= 3'h0;
    end else if (wr && pready) begin
      if (hit_mode) begin
        div_sel_ff <= pwdata[7:5];
        fast_wake_ff <= pwdata[`SCMC_MODE_FAST_BIT];
        idle_en_ff <= pwdata[`SCMC_MODE_IDLE_BIT];
        hl_sel_ff <= pwdata[`SCMC_MODE_HL_BIT];
      end
      if (hit_misc) begin
        idle_syson_ff <= pwdata[`SCMC_MISC_SYSON_BIT];
      end
      if (hit_ctl) begin
        lvd_en_ff <= pwdata[0];
      end
      if (hit_en) begin
        irq_en_ff <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // Mode sequencer.
  // ****************************************
  // low-speed selection means select zero and code below two.
  wire want_low = ~hl_sel_ff & ~div_sel_ff[1] & ~div_sel_ff[2];
  logic use_sub_ff;
  logic refuse_p;
  scmc_mode_t nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    refuse_p = 1'b0;
    case (mode_ff)
      SCMC_NORMAL, SCMC_SLOW: begin
        if (halt_p) begin
          if (idle_en_ff) begin
            nxt_mode = idle_syson_ff ? SCMC_IDLE_CLK : SCMC_IDLE_NOCLK;
          end else if (wdt_on) begin
            nxt_mode = SCMC_SLEEP_LIGHT;
          end else if (lvd_en_ff) begin
            refuse_p = 1'b1;
          end else begin
            nxt_mode = SCMC_SLEEP_DEEP;
          end
        end else begin
          nxt_mode = use_sub_ff ? SCMC_SLOW : SCMC_NORMAL;
        end
      end
      SCMC_IDLE_NOCLK, SCMC_IDLE_CLK, SCMC_SLEEP_DEEP, SCMC_SLEEP_LIGHT: begin
        if (wake_p) begin
          nxt_mode = use_sub_ff ? SCMC_SLOW : SCMC_NORMAL;
        end
      end
      default: nxt_mode = SCMC_NORMAL;
    endcase
  end
  wire asleep = mode_ff != SCMC_NORMAL && mode_ff != SCMC_SLOW;
  // fast wake only with the crystal source and a running substitute clock.
  wire fast_ok = fast_wake_ff & ~opt_hsrc_rc & mode_ff != SCMC_SLEEP_DEEP;
  wire h_off = mode_ff == SCMC_SLEEP_DEEP || mode_ff == SCMC_SLEEP_LIGHT ||
               mode_ff == SCMC_IDLE_NOCLK;

  // ****************************************
  // Oscillator ready counters.
  // ****************************************
  logic [9:0] hcnt_ff;
  logic [7:0] lcnt_ff;
  wire [9:0] h_lim = opt_hsrc_rc ? 10'(`SCMC_HI_RC_READY) : 10'(HI_XTAL_READY);
  wire [7:0] l_lim = opt_lsrc_rc ? 8'(`SCMC_LO_RC_READY) : 8'(`SCMC_LO_XTAL_READY);
  // the high oscillator runs unless slow mode or a stopping mode holds it off.
  wire h_run = ~h_off & ~(use_sub_ff & want_low);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_ff <= 10'h0;
      hrdy_ff <= 1'b0;
    end else if (!h_run) begin
      hcnt_ff <= 10'h0;
      hrdy_ff <= 1'b0;
    end else if (!hrdy_ff && h_tick) begin
      hcnt_ff <= hcnt_ff + 10'h1;
      hrdy_ff <= hcnt_ff + 10'h1 >= h_lim;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_ff <= 8'h0;
      lrdy_ff <= 1'b0;
    end else if (mode_ff == SCMC_SLEEP_DEEP) begin
      lcnt_ff <= 8'h0;
      lrdy_ff <= 1'b0;
    end else if (!lrdy_ff && l_tick) begin
      lcnt_ff <= lcnt_ff + 8'h1;
      lrdy_ff <= lcnt_ff + 8'h1 >= l_lim;
    end
  end

  // Source switch only when the target is ready, so no runt pulse is cut.
  wire nxt_use_sub = use_sub_ff ? ~(~want_low & hrdy_ff) : (want_low & lrdy_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= SCMC_NORMAL;
      use_sub_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      use_sub_ff <= nxt_use_sub;
    end
  end

  // A fast wake-up runs the system clock from the substitute clock until the crystal is ready.
  // The flag is armed at the wake event itself, so it must survive the return to a run mode;
  // waking from deep sleep never arms it, as the substitute clock was stopped there.
  logic fast_run_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_run_ff <= 1'b0;
    end else if (hrdy_ff) begin
      fast_run_ff <= 1'b0;
    end else if (wake_p && asleep && fast_ok) begin
      fast_run_ff <= 1'b1;
    end
  end

  // ****************************************
  // Clock enables.
  // ****************************************
  logic [5:0] div_cnt_ff;
  // Code 010 keeps six counter bits (divide by 64), code 111 keeps one (divide by 2).
  wire [5:0] div_mask = hl_sel_ff ? 6'h00 : 6'h3f >> (div_sel_ff - 3'h2);
  wire on_h = ~use_sub_ff & ~fast_run_ff;
  wire sub_live = mode_ff != SCMC_SLEEP_DEEP &&
                  !(mode_ff == SCMC_SLEEP_LIGHT && !wdt_on);
  wire sys_live = mode_ff == SCMC_NORMAL || mode_ff == SCMC_SLOW || mode_ff == SCMC_IDLE_CLK;
  wire tbc_live = mode_ff != SCMC_SLEEP_DEEP && mode_ff != SCMC_SLEEP_LIGHT;
  wire h_pulse = h_tick & hrdy_ff & ((div_cnt_ff & div_mask) == 6'h0);
  // The divider counts high-speed ticks freely; only reset clears it, a change of code does not restart it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 6'h0;
    end else if (h_tick) begin
      div_cnt_ff <= div_cnt_ff + 6'h1;
    end
  end
  // Registered enables for the downstream gates.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_en <= 1'b0;
      sub_clk_en <= 1'b0;
      tbc_clk_en <= 1'b0;
      cpu_run <= 1'b1;
      hosc_enable <= 1'b1;
      irq <= 1'b0;
    end else begin
      sys_clk_en <= sys_live & (on_h ? h_pulse : l_tick) & ~opt_lsrc_rc | sys_live &
                    (on_h ? h_pulse : l_tick) & opt_lsrc_rc;
      sub_clk_en <= sub_live & l_tick;
      tbc_clk_en <= tbc_live & l_tick & (opt_tbc_rc | ~opt_tbc_rc);
      cpu_run <= nxt_mode == SCMC_NORMAL || nxt_mode == SCMC_SLOW;
      hosc_enable <= h_run;
      irq <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ****************************************
  // Event status: mode entry, refusal, wake.
  // ****************************************
  wire [2:0] ev = {wake_p & asleep, refuse_p, nxt_mode != mode_ff};
  wire [2:0] clr = (wr && pready && hit_clr) ? pwdata[2:0] : 3'h0;
  // Set wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 3'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  AST_SLEEP_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    halt_p && !idle_en_ff && !wdt_on && lvd_en_ff && !asleep |=> mode_ff != SCMC_SLEEP_DEEP)
    else $error("deep sleep entered with low voltage detect on");
  AST_DEEP_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    halt_p && !asleep && !idle_en_ff && !wdt_on && !lvd_en_ff |=> mode_ff == SCMC_SLEEP_DEEP)
    else $error("halt did not enter deep sleep");
  AST_IDLE_NOCLK: assert property (@(posedge pclk) disable iff (!presetn)
    halt_p && !asleep && idle_en_ff && !idle_syson_ff |=> mode_ff == SCMC_IDLE_NOCLK)
    else $error("halt did not enter unclocked idle");
  AST_IDLE_CLK: assert property (@(posedge pclk) disable iff (!presetn)
    halt_p && !asleep && idle_en_ff && idle_syson_ff |=> mode_ff == SCMC_IDLE_CLK)
    else $error("halt did not enter clocked idle");
  AST_LIGHT_SUB: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == SCMC_SLEEP_LIGHT && wdt_on && l_tick |=> sub_clk_en)
    else $error("substitute clock stopped in light sleep");
  // A wake event in deep sleep lets the CPU run again at the next edge.
  AST_NO_SYS_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == SCMC_SLEEP_DEEP && !wake_p |=> !sys_clk_en && !tbc_clk_en && !cpu_run)
    else $error("clock running in deep sleep");
  AST_HRDY_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    h_off |=> !hrdy_ff)
    else $error("high ready set while oscillator stopped");
  AST_LRDY_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == SCMC_SLEEP_DEEP |=> !lrdy_ff)
    else $error("low ready set in deep sleep");
  AST_SWITCH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(use_sub_ff) |-> $past(lrdy_ff))
    else $error("switched to substitute before ready");
  AST_MISC_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && hit_misc && !pwrite |-> prdata[6:3] == 4'h0)
    else $error("unimplemented bits read nonzero");
  AST_SLOW_HOSC: assert property (@(posedge pclk) disable iff (!presetn)
    use_sub_ff && want_low |=> !hosc_enable)
    else $error("high oscillator left running on the substitute clock");
  AST_FAST_SUB: assert property (@(posedge pclk) disable iff (!presetn)
    fast_run_ff && sys_live && l_tick |=> sys_clk_en)
    else $error("fast wake-up did not run on the substitute clock");
  AST_BAD_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !hit_any |=> pready && pslverr)
    else $error("unmapped address not answered with an error");
  // Main scenarios that the bench should reach.
  COV_SLEEP_DEEP: cover property (@(posedge pclk) mode_ff == SCMC_SLEEP_DEEP);
  COV_IDLE_CLK: cover property (@(posedge pclk) mode_ff == SCMC_IDLE_CLK);
  COV_SLOW: cover property (@(posedge pclk) mode_ff == SCMC_SLOW);
  COV_REFUSE: cover property (@(posedge pclk) refuse_p);
  COV_FAST: cover property (@(posedge pclk) fast_run_ff && sys_clk_en);
endmodule
`default_nettype wire

// File: scmc_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scmc_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  // ********************************
  // Signals, rows and the design.
  // ********************************
  typedef struct {logic [11:0] a; logic [7:0] w, m, e; logic err;} scmc_rrow_t;
  typedef struct {logic [7:0] md; logic sy, wd, s, u, t, lr, hr;} scmc_hrow_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hosc_clk_in, losc_clk_in;
  logic opt_hsrc_rc, opt_lsrc_rc, opt_tbc_rc, halt_req, wake_req, wdt_on;
  logic sys_clk_en, sub_clk_en, tbc_clk_en, cpu_run, hosc_enable, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] lcnt;
  logic [7:0] v;
  int n_errors = 0;
  int n_checks = 0;
  int s, u, t, e;
  scmc_rrow_t rrows[9] = '{
    '{`SCMC_OFF_MISC, 8'hf8, 8'hf8, 8'h80, 1'b0}, '{`SCMC_OFF_MISC, 8'h00, 8'hf8, 8'h00, 1'b0},
    '{`SCMC_OFF_MODE, 8'hf3, 8'hf3, 8'hf3, 1'b0}, '{`SCMC_OFF_MODE, 8'h03, 8'hf3, 8'h03, 1'b0},
    '{`SCMC_OFF_IRQ_EN, 8'h07, 8'h07, 8'h07, 1'b0}, '{`SCMC_OFF_IRQ_EN, 8'h00, 8'h07, 8'h00, 1'b0},
    '{`SCMC_OFF_CTL, 8'h01, 8'h01, 8'h01, 1'b0}, '{`SCMC_OFF_CTL, 8'h00, 8'h01, 8'h00, 1'b0},
    '{12'h018, 8'h5a, 8'hff, 8'h00, 1'b1}};
  // Unclocked idle, clocked idle, light sleep, deep sleep.
  scmc_hrow_t hrows[4] = '{'{8'h03, 0, 1, 0, 1, 1, 1, 0}, '{8'h03, 1'b1, 1, 1, 1, 1, 1, 1},
    '{8'h01, 0, 1, 0, 1, 0, 1, 0}, '{8'h01, 0, 0, 0, 0, 0, 0, 0}};
  scmc_top #(.HI_XTAL_READY(64)) u_scmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hosc_clk_in(hosc_clk_in), .losc_clk_in(losc_clk_in),
    .opt_hsrc_rc(opt_hsrc_rc), .opt_lsrc_rc(opt_lsrc_rc), .opt_tbc_rc(opt_tbc_rc),
    .halt_req(halt_req), .wake_req(wake_req), .wdt_on(wdt_on), .sys_clk_en(sys_clk_en),
    .sub_clk_en(sub_clk_en), .tbc_clk_en(tbc_clk_en), .cpu_run(cpu_run),
    .hosc_enable(hosc_enable), .irq(irq));
  // The clock, and oscillators at one half and one eighth of it.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    hosc_clk_in <= ~hosc_clk_in;
    lcnt <= lcnt + 3'h1;
  end
  assign losc_clk_in = lcnt[2];
  // ********************************
  // Bus and power tasks.
  // ********************************
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic er);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    r = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask
  task automatic rd(input logic [11:0] a);
    logic er;
    apb(1'b0, a, 8'h00, v, er);
  endtask
  // Counts the enable pulses seen over n cycles.
  task automatic watch(input int n);
    s = 0; u = 0; t = 0;
    repeat (n) begin
      @(posedge pclk);
      s += sys_clk_en; u += sub_clk_en; t += tbc_clk_en;
    end
  endtask
  task automatic pulse(input logic h);
    if (h) halt_req <= 1'b1; else wake_req <= 1'b1;
    repeat (4) @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wake();
    int k;
    pulse(1'b0);
    for (k = 0; k < 2000 && cpu_run !== 1'b1; k++) @(posedge pclk);
  endtask
  task automatic wait_hready();
    int k;
    k = 0;
    do begin
      rd(`SCMC_OFF_MODE);
      k++;
    end while (v[2] !== 1'b1 && k < 300);
    `CHK("high ready", 1'b1, v[2])
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    results();
  end
  // ********************************
  // Test sequence.
  // ********************************
  initial begin
    {presetn, psel, penable, pwrite, halt_req, wake_req, wdt_on, hosc_clk_in} <= 8'h00;
    {paddr, pwdata, lcnt, opt_hsrc_rc, opt_lsrc_rc, opt_tbc_rc} <= {47'h0, 3'b011};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SCMC_OFF_MODE);
    `CHK("mode reset", 8'h03, v & 8'hf3)
    rd(`SCMC_OFF_MISC);
    `CHK("misc reset", 8'h00, v & 8'hf8)
    wait_hready();
    foreach (rrows[i]) begin
      logic er;
      apb(1'b1, rrows[i].a, rrows[i].w, v, er);
      `CHK("write error", rrows[i].err, er)
      apb(1'b0, rrows[i].a, 8'h00, v, er);
      `CHK("read back", rrows[i].e, v & rrows[i].m)
      `CHK("read error", rrows[i].err, er)
    end
    for (int c = 7; c >= 0; c--) begin
      wr(`SCMC_OFF_MODE, {c[2:0], 5'b00010});
      repeat (300) @(posedge pclk);
      watch(128);
      e = (c < 2) ? 16 : (64 >> (8 - c));
      `CHK("tick count", 1'b1, s >= e - 1 && s <= e + 1)
      `CHK("high osc", c > 1, hosc_enable)
    end
    wr(`SCMC_OFF_MODE, 8'h03);
    repeat (300) @(posedge pclk);
    watch(128);
    `CHK("full rate", 1'b1, s >= 63 && s <= 65)
    foreach (hrows[i]) begin
      wr(`SCMC_OFF_MISC, {hrows[i].sy, 7'h00});
      wdt_on <= hrows[i].wd;
      wr(`SCMC_OFF_MODE, hrows[i].md);
      pulse(1'b1);
      `CHK("cpu halted", 1'b0, cpu_run)
      rd(`SCMC_OFF_MODE);
      `CHK("ready flags", {hrows[i].lr, hrows[i].hr}, v[3:2])
      watch(64);
      `CHK("clocks", {hrows[i].s, hrows[i].u, hrows[i].t}, {s > 0, u > 0, t > 0})
      wake();
      `CHK("cpu woken", 1'b1, cpu_run)
      wait_hready();
    end
    // Pending events stay off the line until enabled.
    `CHK("irq masked", 1'b0, irq)
    wr(`SCMC_OFF_IRQ_EN, 8'h01);
    repeat (2) @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    wr(`SCMC_OFF_IRQ_CLR, 8'h07);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    // Deep sleep with the voltage detector on must be refused.
    wr(`SCMC_OFF_CTL, 8'h01);
    wr(`SCMC_OFF_IRQ_EN, 8'h02);
    wdt_on <= 1'b0;
    wr(`SCMC_OFF_MODE, 8'h01);
    pulse(1'b1);
    `CHK("refused sleep", 1'b1, cpu_run)
    rd(`SCMC_OFF_IRQ_STAT);
    `CHK("refused flag", 1'b1, v[1])
    `CHK("refused irq", 1'b1, irq)
    wr(`SCMC_OFF_IRQ_CLR, 8'h07);
    wr(`SCMC_OFF_CTL, 8'h00);
    // Fast wake-up runs before the crystal is ready again.
    wdt_on <= 1'b1;
    wr(`SCMC_OFF_MODE, 8'h11);
    pulse(1'b1);
    wake();
    watch(40);
    rd(`SCMC_OFF_MODE);
    `CHK("fast wake", 3'b101, {cpu_run, v[2], s > 0})
    wait_hready();
    results();
  end
endmodule
`default_nettype wire
